// ---- uarfe_baud.sv ----
/*
  Bit-rate generator: sixteen-times oversample tick for modes 1 to 3 and the
  shift clock phases for mode 0. Assumes timer overflow inputs are one-cycle
  pulses synchronous to clk_sys_i.
*/
module uarfe_baud
  import uarfe_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  uarfe_baud_if.gen bif
);
  logic [3:0] m0_cnt_r;
  logic [2:0] os_cnt_r;
  wire mode2 = bif.mode == MODE_2;
  wire os_src = mode2 ? 1'b1 : (bif.timer2_sel ? bif.t2_ovf : bif.t1_ovf);
  // Doubler halves the divide; timer 2 is already one event per sample
  wire [2:0] os_div = mode2 ? (M2_OS_DIV >> bif.baud_doubler) :
    (bif.timer2_sel ? T2_OS_DIV : (T1_OS_DIV >> bif.baud_doubler));
  wire os_last = os_cnt_r >= os_div - 3'h1;
  wire m0_last = m0_cnt_r == M0_DIV_LAST;

  assign bif.os_tick = bif.ce & os_src & os_last;
  assign bif.m0_fall = bif.ce & (m0_cnt_r == M0_FALL_AT);
  assign bif.m0_rise = bif.ce & m0_last;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      m0_cnt_r <= 4'h0;
    end else if (bif.ce) begin
      m0_cnt_r <= m0_last ? 4'h0 : m0_cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      os_cnt_r <= 3'h0;
    end else if (bif.ce && os_src) begin
      os_cnt_r <= os_last ? 3'h0 : os_cnt_r + 3'h1;
    end
  end
endmodule

// ---- uarfe_baud_if.sv ----
/*
  Interface between the serial port core and its bit-rate generator.
  Assumes one clock; tick outputs are one-cycle pulses.
*/
interface uarfe_baud_if;
  logic [1:0] mode;
  logic baud_doubler;
  logic timer2_sel;
  logic t1_ovf;
  logic t2_ovf;
  logic ce;
  logic os_tick;
  logic m0_fall;
  logic m0_rise;
  modport gen (input mode, baud_doubler, timer2_sel, t1_ovf, t2_ovf, ce,
    output os_tick, m0_fall, m0_rise);
  modport core (output mode, baud_doubler, timer2_sel, t1_ovf, t2_ovf, ce,
    input os_tick, m0_fall, m0_rise);
endinterface

// ---- uarfe_pkg.sv ----
/*
  Package of the serial port with address recognition and frame error
  detection: register offsets, field positions, reset values, divider counts
  and state types. Assumes a 20 MHz system clock that also serves as the
  oscillator reference for modes 0 and 2.
*/
package uarfe_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_BUF = 3'h1;
  localparam logic [2:0] REG_MATCH_VAL = 3'h2;
  localparam logic [2:0] REG_MATCH_MASK = 3'h3;
  localparam logic [2:0] REG_PWR_CTRL = 3'h4;
  localparam logic [2:0] REG_BAUD_SRC = 3'h5;

  // ==========================================================
  // Field positions
  localparam int CTRL_MODE_HI = 7;
  localparam int CTRL_MODE_LO = 6;
  localparam int CTRL_FILTER = 5;
  localparam int CTRL_RX_EN = 4;
  localparam int CTRL_TX9 = 3;
  localparam int CTRL_RX9 = 2;
  localparam int CTRL_TX_DONE = 1;
  localparam int CTRL_RX_DONE = 0;
  localparam int PWR_DOUBLER = 7;
  localparam int PWR_VIEW_SEL = 6;
  localparam int SRC_TIMER2 = 0;

  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic RST_BIT = 1'b0;

  // ==========================================================
  // Modes and timing counts
  localparam logic [1:0] MODE_0 = 2'h0;
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;
  localparam logic [1:0] MODE_3 = 2'h3;
  localparam logic [3:0] M0_DIV_LAST = 4'hb;
  localparam logic [3:0] M0_FALL_AT = 4'h5;
  localparam logic [2:0] M2_OS_DIV = 3'h4;
  localparam logic [2:0] T1_OS_DIV = 3'h2;
  localparam logic [2:0] T2_OS_DIV = 3'h1;
  localparam logic [3:0] OS_LAST = 4'hf;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] M0_BITS_LAST = 4'h7;
  localparam logic [3:0] M1_TX_LAST = 4'h9;
  localparam logic [3:0] M23_TX_LAST = 4'ha;
  localparam logic [3:0] M1_RX_LAST = 4'h8;
  localparam logic [3:0] M23_RX_LAST = 4'h9;

  typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} uarfe_tx_state_type;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_SYNC} uarfe_rx_state_type;
endpackage

// ---- uarfe_remote.sv ----
/*
  Remote serial device on the line side of uarfe_top: sends frames on the
  receive line and samples frames from the transmit line.
  Assumes its tasks are entered just after a rising clock edge.
*/
module uarfe_remote (
  input wire logic clk_sys_i,
  input wire logic txd_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Line driver, idles at mark level
  initial line_o = 1'b1;

  // Bit 0 goes first: start, data LSB first, ninth, stop
  task automatic send(input logic [10:0] bits, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      line_o <= bits[i];
      repeat (per) @(posedge clk_sys_i);
    end
    line_o <= 1'b1;
  endtask

  task automatic hold(input logic lvl);
    line_o <= lvl;
  endtask

  // ==========================================================
  // Line receiver, samples in mid-bit
  task automatic recv(input int n, input int per, output logic [10:0] bits);
    bits = '0;
    @(negedge txd_i);
    repeat (per / 2) @(posedge clk_sys_i);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd_i;
      repeat (per) @(posedge clk_sys_i);
    end
  endtask
endmodule

// ---- uarfe_top.sv ----
/*
  Serial port with four modes, ninth bit, address recognition and frame
  error detection, behind a plain strobe register port. Assumes all pins and
  timer overflow pulses are synchronous to clk_sys_i.
*/
module uarfe_top
  import uarfe_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [2:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic t1_ovf_i,
  input wire logic t2_ovf_i,
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe_n_o,
  output logic txd_o
);
  // ==========================================================
  // Registers
  logic sm0_r, sm1_r, sm2_r, ren_r, tb8_r, rb8_r, ti_r, ri_r, fe_r;
  logic baud_doubler_r, error_bit_view_select_r, t2sel_r;
  logic [7:0] tx_buf_r, rx_buf_r, match_val_r, match_mask_r, rdata_r;
  uarfe_tx_state_type tx_state_r;
  uarfe_rx_state_type rx_state_r;
  logic [10:0] tx_shift_r;
  logic [9:0] rx_shift_r;
  logic [3:0] tx_bits_r, tx_os_r, rx_bits_r, rx_os_r;
  logic rxd_q_r, txd_r, rxd_out_r, rxd_oe_n_r;

  uarfe_baud_if bif ();
  uarfe_baud u_baud (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .bif(bif)
  );

  // ==========================================================
  // Register decode
  wire [1:0] mode = {sm0_r, sm1_r};
  wire mode0 = mode == MODE_0;
  wire mode1 = mode == MODE_1;
  wire wr_ctrl = ce_i & reg_wr_i & (reg_addr_i == REG_CTRL);
  wire wr_buf = ce_i & reg_wr_i & (reg_addr_i == REG_BUF);
  wire wr_val = ce_i & reg_wr_i & (reg_addr_i == REG_MATCH_VAL);
  wire wr_mask = ce_i & reg_wr_i & (reg_addr_i == REG_MATCH_MASK);
  wire wr_pwr = ce_i & reg_wr_i & (reg_addr_i == REG_PWR_CTRL);
  wire wr_src = ce_i & reg_wr_i & (reg_addr_i == REG_BAUD_SRC);
  wire bit7_rd = error_bit_view_select_r ? fe_r : sm0_r;
  wire [7:0] ctrl_rd = {bit7_rd, sm1_r, sm2_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};
  wire [7:0] rd_mux =
    (reg_addr_i == REG_CTRL) ? ctrl_rd :
    (reg_addr_i == REG_BUF) ? rx_buf_r :
    (reg_addr_i == REG_MATCH_VAL) ? match_val_r :
    (reg_addr_i == REG_MATCH_MASK) ? match_mask_r :
    (reg_addr_i == REG_PWR_CTRL) ? {baud_doubler_r, error_bit_view_select_r, 6'h00} :
    (reg_addr_i == REG_BAUD_SRC) ? {7'h00, t2sel_r} : 8'h00;

  assign bif.mode = mode;
  assign bif.baud_doubler = baud_doubler_r;
  assign bif.timer2_sel = t2sel_r;
  assign bif.t1_ovf = t1_ovf_i;
  assign bif.t2_ovf = t2_ovf_i;
  assign bif.ce = ce_i;

  // ==========================================================
  // Transmitter
  wire tx_busy = tx_state_r == TX_SHIFT;
  wire tx_ninth = mode1 ? 1'b1 : tb8_r;
  wire [10:0] tx_load = mode0 ? {3'h7, reg_wdata_i} :
    {1'b1, tx_ninth, reg_wdata_i, 1'b0};
  wire [3:0] tx_last = mode0 ? M0_BITS_LAST : (mode1 ? M1_TX_LAST : M23_TX_LAST);
  // Mode 0 shifts only at a rise that follows a full low phase of the clock
  wire m0_step = bif.m0_rise & ~txd_r;
  wire tx_step = mode0 ? m0_step : (bif.os_tick & (tx_os_r == OS_LAST));
  wire tx_done = tx_busy & tx_step & (tx_bits_r == tx_last);

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tx_state_r <= TX_IDLE;
      tx_shift_r <= 11'h7ff;
      tx_bits_r <= 4'h0;
      tx_os_r <= 4'h0;
    end else if (ce_i) begin
      if (wr_buf) begin
        tx_state_r <= TX_SHIFT;
        tx_shift_r <= tx_load;
        tx_bits_r <= 4'h0;
        tx_os_r <= 4'h0;
      end else if (tx_busy) begin
        if (bif.os_tick) tx_os_r <= tx_os_r + 4'h1;
        if (tx_step) begin
          tx_shift_r <= {1'b1, tx_shift_r[10:1]};
          tx_bits_r <= tx_bits_r + 4'h1;
          if (tx_done) tx_state_r <= TX_IDLE;
        end
      end
    end
  end

  // ==========================================================
  // Receiver
  wire rx_m0_go = mode0 & ren_r & ~ri_r & ~tx_busy;
  wire rx_edge = ~mode0 & ren_r & rxd_q_r & ~rxd_i;
  wire [9:0] rx_full = {rxd_i, rx_shift_r[9:1]};
  wire [3:0] rx_last = mode0 ? M0_BITS_LAST : (mode1 ? M1_RX_LAST : M23_RX_LAST);
  wire rx_step = (rx_state_r == RX_SYNC) ? m0_step :
    (bif.os_tick & (rx_os_r == OS_LAST));
  wire rx_end = (rx_state_r == RX_SYNC || rx_state_r == RX_DATA) & rx_step &
    (rx_bits_r == rx_last);
  wire [7:0] rx_byte = mode0 ? rx_full[9:2] : (mode1 ? rx_full[8:1] : rx_full[7:0]);
  wire rx_ninth = mode1 ? rx_full[9] : rx_full[8];
  wire rx_stop = rx_full[9];
  // Don't-care bits come from a zero mask bit
  wire given_ok = &(~((rx_byte ^ match_val_r) & match_mask_r));
  wire [7:0] bcast = match_val_r | match_mask_r;
  wire bcast_ok = &(rx_byte | ~bcast);
  wire addr_ok = given_ok | bcast_ok;
  wire rx_accept = mode0 | ~sm2_r | (addr_ok & (mode1 ? rx_stop : rx_ninth));
  wire rx_done = rx_end & rx_accept;
  wire fe_set = rx_end & ~mode0 & ~rx_stop;

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rx_state_r <= RX_IDLE;
      rx_shift_r <= 10'h000;
      rx_bits_r <= 4'h0;
      rx_os_r <= 4'h0;
    end else if (ce_i) begin
      if (bif.os_tick) rx_os_r <= rx_os_r + 4'h1;
      unique case (rx_state_r)
        RX_IDLE: begin
          rx_bits_r <= 4'h0;
          if (rx_m0_go) rx_state_r <= RX_SYNC;
          else if (rx_edge) begin
            rx_state_r <= RX_START;
            rx_os_r <= 4'h0;
          end
        end
        RX_START: begin
          // Glitch shorter than half a bit returns to idle
          if (bif.os_tick && rx_os_r == OS_MID) begin
            rx_state_r <= rxd_i ? RX_IDLE : RX_DATA;
            rx_os_r <= 4'h0;
          end
        end
        RX_DATA, RX_SYNC: begin
          if (rx_step) begin
            rx_shift_r <= rx_full;
            rx_bits_r <= rx_bits_r + 4'h1;
            if (rx_end) rx_state_r <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Control and status flags; hardware set wins over software clear
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      {sm0_r, sm1_r, sm2_r, ren_r, tb8_r, rb8_r} <= 6'h00;
      {ti_r, ri_r, fe_r} <= 3'h0;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        if (!error_bit_view_select_r) sm0_r <= reg_wdata_i[CTRL_MODE_HI];
        sm1_r <= reg_wdata_i[CTRL_MODE_LO];
        sm2_r <= reg_wdata_i[CTRL_FILTER];
        ren_r <= reg_wdata_i[CTRL_RX_EN];
        tb8_r <= reg_wdata_i[CTRL_TX9];
      end
      if (rx_done && !mode0) rb8_r <= rx_ninth;
      else if (wr_ctrl) rb8_r <= reg_wdata_i[CTRL_RX9];
      ti_r <= tx_done | (wr_ctrl ? reg_wdata_i[CTRL_TX_DONE] : ti_r);
      ri_r <= rx_done | (wr_ctrl ? reg_wdata_i[CTRL_RX_DONE] : ri_r);
      fe_r <= fe_set | ((wr_ctrl && error_bit_view_select_r) ? reg_wdata_i[CTRL_MODE_HI] : fe_r);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      tx_buf_r <= RST_BYTE;
      rx_buf_r <= RST_BYTE;
      match_val_r <= RST_BYTE;
      match_mask_r <= RST_BYTE;
      {baud_doubler_r, error_bit_view_select_r, t2sel_r} <= 3'h0;
      rdata_r <= RST_BYTE;
    end else if (ce_i) begin
      if (wr_buf) tx_buf_r <= reg_wdata_i;
      if (rx_done) rx_buf_r <= rx_byte;
      if (wr_val) match_val_r <= reg_wdata_i;
      if (wr_mask) match_mask_r <= reg_wdata_i;
      if (wr_pwr) {baud_doubler_r, error_bit_view_select_r} <= reg_wdata_i[PWR_DOUBLER:PWR_VIEW_SEL];
      if (wr_src) t2sel_r <= reg_wdata_i[SRC_TIMER2];
      rdata_r <= reg_rd_i ? rd_mux : RST_BYTE;
    end
  end

  // ==========================================================
  // Pins; mode 0 drives data on the receive pin, clock on transmit pin
  wire m0_active = mode0 & (tx_busy | rx_state_r == RX_SYNC);
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rxd_q_r <= 1'b1;
      txd_r <= 1'b1;
      rxd_out_r <= 1'b1;
      rxd_oe_n_r <= 1'b1;
    end else if (ce_i) begin
      rxd_q_r <= rxd_i;
      rxd_oe_n_r <= ~(mode0 & tx_busy);
      rxd_out_r <= tx_shift_r[0];
      if (!mode0) txd_r <= tx_busy ? tx_shift_r[0] : 1'b1;
      else if (m0_active && bif.m0_fall) txd_r <= 1'b0;
      else if (bif.m0_rise || !m0_active) txd_r <= 1'b1;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign txd_o = txd_r;
  assign rxd_o = rxd_out_r;
  assign rxd_oe_n_o = rxd_oe_n_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  chk_tx_starts: assert property (wr_buf |=> tx_busy && tx_bits_r == 4'h0)
    else $error("buffer write did not start transmission");
  chk_tx_ninth_bit: assert property (wr_buf && mode[1] |=> tx_shift_r[9] == $past(tb8_r))
    else $error("ninth bit not loaded from tx_ninth_bit");
  chk_m0_rx_start: assert property (ce_i && rx_state_r == RX_IDLE && rx_m0_go
    |=> rx_state_r == RX_SYNC)
    else $error("mode 0 reception did not begin");
  chk_rx_disabled: assert property (!ren_r && rx_state_r == RX_IDLE && !wr_ctrl
    |=> rx_state_r == RX_IDLE)
    else $error("reception began while disabled");
  chk_fe_sticky: assert property (fe_r && !(wr_ctrl && error_bit_view_select_r) |=> fe_r)
    else $error("framing error cleared without software");
  chk_bit7_view: assert property (ce_i && reg_rd_i && reg_addr_i == REG_CTRL
    |=> reg_rdata_o[7] == $past(bit7_rd) && $past(error_bit_view_select_r) == error_bit_view_select_r)
    else $error("control bit 7 read wrong");
  chk_filter_ninth: assert property ($rose(ri_r) && mode[1] && sm2_r && !$past(wr_ctrl)
    |-> rb8_r)
    else $error("filtered receive done without ninth bit");
  chk_filter_stop: assert property (rx_end && mode1 && sm2_r && !rx_stop
    |=> !$rose(ri_r))
    else $error("filtered mode 1 done with bad stop bit");
  chk_tx_done_flag: assert property (tx_done |=> ti_r ##1 (ti_r || $past(wr_ctrl)))
    else $error("transmit done flag not set");
  chk_idle_line: assert property (!mode0 && !tx_busy && $past(!tx_busy) |=> txd_o)
    else $error("transmit line not idle high");

  cov_rx_done: cover property ($rose(ri_r));
  cov_tx_done: cover property ($rose(ti_r));
  cov_frame_err: cover property ($rose(fe_r));
  cov_m0_rx: cover property (rx_end && mode0);
endmodule

// ---- uarfe_top_tb_top.sv ----
/*
  Self-checking testbench of uarfe_top: register accesses, frames in all
  modes, address filtering and framing error.
  Assumes uarfe_remote on the line side and timer overflows every 2 cycles.
*/
module uarfe_top_tb_top import uarfe_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [2:0] reg_addr_i = 3'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic t1_ovf_i = 1'b0;
  logic t2_ovf_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic rxd_o, rxd_oe_n_o, txd_o, remote_line, rxd_line;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [10:0] got;
  logic [7:0] v;
  logic [7:0] t_pw [5] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0] t_src [5] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00};
  logic [7:0] t_ct [5] = '{8'h88, 8'h80, 8'hc8, 8'hc0, 8'h40};
  logic [7:0] t_d [5] = '{8'ha5, 8'h5a, 8'h96, 8'h3c, 8'h81};
  int t_per [5] = '{32, 64, 32, 64, 64};
  logic [7:0] f_d [7] = '{8'hc0, 8'hc2, 8'hc1, 8'hc0, 8'hfd, 8'hff, 8'h7d};
  logic f_9 [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
  logic f_ok [7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};

  // Shared pin: device drives only while its enable is low
  assign rxd_line = rxd_oe_n_o ? remote_line : rxd_o;

  uarfe_top uarfe_top_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .t1_ovf_i(t1_ovf_i),
    .t2_ovf_i(t2_ovf_i), .rxd_i(rxd_line), .rxd_o(rxd_o), .rxd_oe_n_o(rxd_oe_n_o),
    .txd_o(txd_o));
  uarfe_remote uarfe_remote_inst (.clk_sys_i(clk_sys_i), .txd_i(txd_o),
    .line_o(remote_line));

  // ==========================================================
  // Clock, timer overflows, hang guard
  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i) begin
    t1_ovf_i <= ~t1_ovf_i;
    t2_ovf_i <= ~t2_ovf_i;
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      failures++;
      end_of_test();
    end
  end

  // ==========================================================
  // Access tasks
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [10:0] seen, input logic [10:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_sys_i);
    v = reg_rdata_o;
    @(posedge clk_sys_i);
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    rd(a);
    check({3'h0, v}, {3'h0, e});
  endtask

  task automatic poll(input logic [7:0] m);
    for (int i = 0; i < 100; i++) begin
      rd(REG_CTRL);
      if ((v & m) != 8'h00) break;
    end
  endtask

  // ==========================================================
  // Test sequence
  initial begin
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    wr(3'h6, 8'hff);
    for (int a = 0; a < 8; a++) rdc(3'(a), 8'h00);
    wr(REG_MATCH_VAL, 8'hc0);
    wr(REG_MATCH_MASK, 8'hfd);
    rdc(REG_MATCH_VAL, 8'hc0);
    rdc(REG_MATCH_MASK, 8'hfd);
    $display("test registers done");
    // Byte 00 fails both addresses, mode 0 must take it anyway
    uarfe_remote_inst.hold(1'b0);
    wr(REG_CTRL, 8'h30);
    poll(8'h01);
    rdc(REG_BUF, 8'h00);
    uarfe_remote_inst.hold(1'b1);
    wr(REG_CTRL, 8'h00);
    got = '0;
    fork
      for (int i = 0; i < 8; i++) begin
        @(negedge txd_o);
        #1;
        got[i] = rxd_o;
        check({10'h0, rxd_oe_n_o}, 11'h0);
      end
      wr(REG_BUF, 8'h3c);
    join
    check(got, {3'h0, 8'h3c});
    poll(8'h02);
    rdc(REG_CTRL, 8'h02);
    $display("test mode 0 done");
    for (int k = 0; k < 5; k++) begin
      wr(REG_PWR_CTRL, t_pw[k]);
      wr(REG_BAUD_SRC, t_src[k]);
      wr(REG_CTRL, t_ct[k]);
      fork
        uarfe_remote_inst.recv(t_ct[k][7] ? 11 : 10, t_per[k], got);
        wr(REG_BUF, t_d[k]);
      join
      check(got, t_ct[k][7] ? {1'b1, t_ct[k][3], t_d[k], 1'b0} : {2'b01, t_d[k], 1'b0});
      rdc(REG_CTRL, t_ct[k] | 8'h02);
    end
    $display("test transmit done");
    wr(REG_PWR_CTRL, 8'h00);
    wr(REG_BAUD_SRC, 8'h00);
    for (int k = 0; k < 7; k++) begin
      wr(REG_CTRL, 8'hb0);
      uarfe_remote_inst.send({1'b1, f_9[k], f_d[k], 1'b0}, 11, 64);
      rdc(REG_CTRL, f_ok[k] ? 8'hb5 : 8'hb0);
      if (f_ok[k]) rdc(REG_BUF, f_d[k]);
    end
    wr(REG_CTRL, 8'h80);
    uarfe_remote_inst.send({1'b1, 1'b1, 8'h3c, 1'b0}, 11, 64);
    rdc(REG_CTRL, 8'h80);
    wr(REG_CTRL, 8'h94);
    uarfe_remote_inst.send({1'b1, 1'b0, 8'h3c, 1'b0}, 11, 64);
    rdc(REG_CTRL, 8'h91);
    rdc(REG_BUF, 8'h3c);
    $display("test receive done");
    // Mode 1 with filter: bad stop first, then a good frame
    wr(REG_MATCH_VAL, 8'h55);
    wr(REG_MATCH_MASK, 8'hff);
    wr(REG_CTRL, 8'h70);
    uarfe_remote_inst.send({2'b00, 8'h55, 1'b0}, 10, 64);
    wr(REG_PWR_CTRL, 8'h40);
    rdc(REG_CTRL, 8'hf0);
    uarfe_remote_inst.send({2'b01, 8'h55, 1'b0}, 10, 64);
    rdc(REG_CTRL, 8'hf5);
    rdc(REG_BUF, 8'h55);
    wr(REG_CTRL, 8'h70);
    rdc(REG_CTRL, 8'h70);
    wr(REG_PWR_CTRL, 8'h00);
    rdc(REG_CTRL, 8'h70);
    $display("test framing done");
    end_of_test();
  end
endmodule
